/* File: rtl/drc_pkg.sv */
// Purpose: Constants for the drive command, reference and ramp block
// Assumes: 25 MHz pclk, APB register access, references in 0.01 Hz units
// Notes: Offsets are byte addresses of aligned 32-bit words
package drc_pkg;
  // Register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_FREQ = 12'h004;
  localparam logic [11:0] ADDR_ANALOG = 12'h008;
  localparam logic [11:0] ADDR_RAMP_A = 12'h00C;
  localparam logic [11:0] ADDR_RAMP_B = 12'h010;
  localparam logic [11:0] ADDR_INFUNC = 12'h014;
  localparam logic [11:0] ADDR_PANEL_REF = 12'h018;
  localparam logic [11:0] ADDR_STATUS = 12'h01C;
  localparam logic [11:0] ADDR_JOG = 12'h020;
  localparam logic [11:0] ADDR_PRESET_BASE = 12'h040;
  localparam logic [11:0] ADDR_PRESET_LAST = 12'h07C;
  // CTRL field positions
  localparam int CTRL_RUN_SRC_LSB = 0;
  localparam int CTRL_REM_REF_LSB = 4;
  localparam int CTRL_LOC_REF_BIT = 8;
  localparam int CTRL_ENTER_BIT = 9;
  localparam int CTRL_REV_PROH_BIT = 10;
  localparam int CTRL_ANA_STEP_BIT = 11;
  localparam int CTRL_PANEL_DET_BIT = 12;
  localparam int CTRL_LOCAL_BIT = 13;
  localparam int CTRL_UNIT_BIT = 16;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0110;
  localparam logic [15:0] MAX_FREQ_RST = 16'h0258;
  localparam logic [15:0] MIN_FREQ_RST = 16'h000F;
  localparam logic [7:0] GAIN_RST = 8'h64;
  localparam logic [7:0] BIAS_RST = 8'h00;
  localparam logic [7:0] UPPER_RST = 8'h64;
  localparam logic [7:0] LOWER_RST = 8'h00;
  localparam logic [15:0] RAMP_TIME_RST = 16'h0064;
  localparam logic [15:0] JOG_RST = 16'h0258;
  localparam logic [15:0] PRESET_RST = 16'h0000;
  localparam logic [27:0] INFUNC_RST = 28'hA765321;
  // Contact input function codes
  localparam logic [3:0] FN_FWD = 4'h1;
  localparam logic [3:0] FN_REV = 4'h2;
  localparam logic [3:0] FN_STEP1 = 4'h6;
  localparam logic [3:0] FN_STEP2 = 4'h7;
  localparam logic [3:0] FN_STEP3 = 4'h8;
  localparam logic [3:0] FN_STEP4 = 4'h9;
  localparam logic [3:0] FN_JOG = 4'hA;
  localparam logic [3:0] FN_RAMP_SEL = 4'hB;
  localparam logic [3:0] FN_LOC_REM = 4'hC;
  localparam int NUM_CONTACTS = 7;
  // Ramp time encoding and timing
  localparam logic [15:0] RAW_COARSE = 16'h2710;
  localparam logic [15:0] RAW_OFFSET = 16'h2328;
  localparam logic [15:0] RAW_MAX = 16'h3A98;
  localparam logic [19:0] FINE_UNIT_LIMIT_CS = 20'h0EA60;
  localparam int CLK_HZ = 25_000_000;
  localparam int CS_PER_S = 100;
  localparam int CYC_PER_CS = CLK_HZ / CS_PER_S;
  // Analog scaling
  localparam logic [11:0] ANA_FULL = 12'hFFF;
  localparam logic [11:0] ANA_4MA = 12'h333;
  localparam int PCT_FULL = 100;
  localparam int DHZ_TO_CHZ = 10;
  typedef enum logic [1:0] {
    DRC_RUN_PANEL, DRC_RUN_CONTACT, DRC_RUN_SERIAL, DRC_RUN_OPTION
  } drc_run_src_t;
  typedef enum logic [3:0] {
    DRC_REF_POT, DRC_REF_PRESET, DRC_REF_VOLT, DRC_REF_CUR420, DRC_REF_CUR020,
    DRC_REF_PULSE, DRC_REF_SERIAL, DRC_REF_PVOLT, DRC_REF_PCUR, DRC_REF_OPTION
  } drc_ref_src_t;
endpackage

/* File: rtl/drc_top.sv */
// Purpose: Command source, reference selection, limiting and ramp of a motor drive
// Assumes: Inputs synchronous to pclk; panel key inputs are one-cycle pulses
// Notes: APB slave with zero wait states; unmapped addresses answer pslverr
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module drc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic panel_run_key,
  input wire logic panel_stop_key,
  input wire logic panel_dir_rev,
  input wire logic panel_enter_key,
  input wire logic [11:0] panel_pot,
  input wire logic [6:0] contact_in,
  input wire logic serial_run_fwd,
  input wire logic serial_run_rev,
  input wire logic [15:0] serial_freq_ref,
  input wire logic option_run_fwd,
  input wire logic option_run_rev,
  input wire logic [15:0] option_freq_ref,
  input wire logic [11:0] analog_ref_input_pin,
  input wire logic [11:0] analog_cur_in,
  input wire logic [15:0] pulse_freq_ref,
  input wire logic [11:0] panel_volt_in,
  input wire logic [11:0] panel_cur_in,
  input wire logic [11:0] aux_analog_connector,
  output logic [15:0] out_freq,
  output logic out_reverse,
  output logic out_running,
  output logic local_mode
);
  logic [31:0] ctrl_q;
  logic [15:0] max_output_freq, min_output_freq;
  logic [7:0] analog_ref_gain, analog_ref_bias, ref_upper_limit, ref_lower_limit;
  logic [15:0] accel_time_a, decel_time_a, accel_time_b, decel_time_b;
  logic [27:0] input_function_sel;
  logic [15:0] panel_entry_q, panel_ref_q, jog_freq_ref;
  logic [15:0] preset_q [16];
  logic panel_run_q;
  logic [15:0] freq_q;
  logic rev_q;
  logic [39:0] acc_q;

  logic wr_en, rd_en, addr_ok, preset_hit;
  logic [3:0] preset_idx;
  logic [1:0] run_cmd_source_sel;
  logic [3:0] remote_ref_source_sel;
  logic local_ref_source_sel, enter_key_mode, reverse_prohibit, analog_step_sel;
  logic ramp_time_unit_sel;
  localparam int NUM_FN_W = 16;
  logic [NUM_FN_W-1:0] fn_on;
  logic locrem_assigned;
  logic [3:0] step_idx;
  logic run_fwd, run_rev, run_cmd, want_rev;
  logic [15:0] base_ref, sel_ref, lim_ref, target;
  logic [15:0] upper_chz, lower_chz, min_chz, max_chz;
  logic no_run;
  logic [19:0] acc_cs, dec_cs, time_cs, ta_cs, tb_cs, tc_cs, td_cs;
  logic [39:0] thresh, acc_sum;
  logic unit_ok;

  assign run_cmd_source_sel = ctrl_q[drc_pkg::CTRL_RUN_SRC_LSB +: 2];
  assign remote_ref_source_sel = ctrl_q[drc_pkg::CTRL_REM_REF_LSB +: 4];
  assign local_ref_source_sel = ctrl_q[drc_pkg::CTRL_LOC_REF_BIT];
  assign enter_key_mode = ctrl_q[drc_pkg::CTRL_ENTER_BIT];
  assign reverse_prohibit = ctrl_q[drc_pkg::CTRL_REV_PROH_BIT];
  assign analog_step_sel = ctrl_q[drc_pkg::CTRL_ANA_STEP_BIT];
  assign ramp_time_unit_sel = ctrl_q[drc_pkg::CTRL_UNIT_BIT];

  // Raw ramp setting to hundredths of a second in the current unit
  function automatic logic [19:0] to_cs(input logic [15:0] raw, input logic fine);
    logic [19:0] r, c;
    r = {4'h0, raw};
    c = r - {4'h0, drc_pkg::RAW_OFFSET};
    if (fine) begin
      to_cs = (raw < drc_pkg::RAW_COARSE) ? r : 20'(c * 20'd10);
    end else begin
      to_cs = (raw < drc_pkg::RAW_COARSE) ? 20'(r * 20'd10) : 20'(c * 20'd100);
    end
  endfunction

  // Analog code to 0.01 Hz through bias and gain, saturating at both ends
  function automatic logic [15:0] scale_ref(input logic [11:0] x, input logic live_zero,
                                            input logic [15:0] maxf, input logic [7:0] gain,
                                            input logic [7:0] bias);
    logic signed [63:0] frac, pct, res;
    frac = 64'(x);
    if (live_zero) begin
      frac = (x < drc_pkg::ANA_4MA) ? 64'sd0 :
             ((64'(x) - 64'(drc_pkg::ANA_4MA)) * 64'(drc_pkg::ANA_FULL)) /
             (64'(drc_pkg::ANA_FULL) - 64'(drc_pkg::ANA_4MA));
    end
    pct = 64'(bias) * 64'(drc_pkg::ANA_FULL) + (64'(gain) - 64'(bias)) * frac;
    res = (64'(maxf) * drc_pkg::DHZ_TO_CHZ * pct) /
          (64'(drc_pkg::PCT_FULL) * 64'(drc_pkg::ANA_FULL));
    if (res < 0) begin
      scale_ref = 16'h0000;
    end else if (res > 64'sd65535) begin
      scale_ref = 16'hFFFF;
    end else begin
      scale_ref = res[15:0];
    end
  endfunction

  // Percent of max frequency to 0.01 Hz
  function automatic logic [15:0] pct_chz(input logic [15:0] maxf, input logic [7:0] pct);
    logic [31:0] p;
    p = (32'(maxf) * 32'(drc_pkg::DHZ_TO_CHZ) * 32'(pct)) / 32'(drc_pkg::PCT_FULL);
    pct_chz = (p > 32'h0000_FFFF) ? 16'hFFFF : p[15:0];
  endfunction

  // APB decode; always ready, so the access phase is one cycle
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign preset_hit = (paddr >= drc_pkg::ADDR_PRESET_BASE) &&
                      (paddr <= drc_pkg::ADDR_PRESET_LAST) && (paddr[1:0] == 2'b00);
  assign preset_idx = paddr[5:2];
  always_comb begin
    unique case (paddr)
      drc_pkg::ADDR_CTRL, drc_pkg::ADDR_FREQ, drc_pkg::ADDR_ANALOG, drc_pkg::ADDR_RAMP_A,
      drc_pkg::ADDR_RAMP_B, drc_pkg::ADDR_INFUNC, drc_pkg::ADDR_PANEL_REF,
      drc_pkg::ADDR_STATUS, drc_pkg::ADDR_JOG: addr_ok = 1'b1;
      default: addr_ok = preset_hit;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        drc_pkg::ADDR_CTRL: prdata = ctrl_q;
        drc_pkg::ADDR_FREQ: prdata = {min_output_freq, max_output_freq};
        drc_pkg::ADDR_ANALOG: prdata = {ref_lower_limit, ref_upper_limit,
                                        analog_ref_bias, analog_ref_gain};
        drc_pkg::ADDR_RAMP_A: prdata = {decel_time_a, accel_time_a};
        drc_pkg::ADDR_RAMP_B: prdata = {decel_time_b, accel_time_b};
        drc_pkg::ADDR_INFUNC: prdata = {4'h0, input_function_sel};
        drc_pkg::ADDR_PANEL_REF: prdata = {panel_ref_q, panel_entry_q};
        drc_pkg::ADDR_STATUS: prdata = {4'h0, step_idx, 5'h00, local_mode, out_running,
                                        out_reverse, freq_q};
        drc_pkg::ADDR_JOG: prdata = {16'h0000, jog_freq_ref};
        default: prdata = preset_hit ? {16'h0000, preset_q[preset_idx]} : 32'h0000_0000;
      endcase
    end
  end

  // Fine unit is only accepted when no ramp time is beyond 600.0 s
  assign ta_cs = to_cs(accel_time_a, 1'b0);
  assign tb_cs = to_cs(decel_time_a, 1'b0);
  assign tc_cs = to_cs(accel_time_b, 1'b0);
  assign td_cs = to_cs(decel_time_b, 1'b0);
  assign unit_ok = (ta_cs <= drc_pkg::FINE_UNIT_LIMIT_CS) &&
                   (tb_cs <= drc_pkg::FINE_UNIT_LIMIT_CS) &&
                   (tc_cs <= drc_pkg::FINE_UNIT_LIMIT_CS) &&
                   (td_cs <= drc_pkg::FINE_UNIT_LIMIT_CS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= drc_pkg::CTRL_RST;
    end else if (wr_en && paddr == drc_pkg::ADDR_CTRL) begin
      ctrl_q[15:0] <= pwdata[15:0];
      // Unit reinterprets stored times, so it may only move while stopped
      if (!out_running && (!pwdata[drc_pkg::CTRL_UNIT_BIT] || ramp_time_unit_sel || unit_ok)) begin
        ctrl_q[drc_pkg::CTRL_UNIT_BIT] <= pwdata[drc_pkg::CTRL_UNIT_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_output_freq <= drc_pkg::MAX_FREQ_RST;
      min_output_freq <= drc_pkg::MIN_FREQ_RST;
      analog_ref_gain <= drc_pkg::GAIN_RST;
      analog_ref_bias <= drc_pkg::BIAS_RST;
      ref_upper_limit <= drc_pkg::UPPER_RST;
      ref_lower_limit <= drc_pkg::LOWER_RST;
      input_function_sel <= drc_pkg::INFUNC_RST;
      jog_freq_ref <= drc_pkg::JOG_RST;
    end else if (wr_en) begin
      unique case (paddr)
        drc_pkg::ADDR_FREQ: begin
          max_output_freq <= pwdata[15:0];
          min_output_freq <= pwdata[31:16];
        end
        drc_pkg::ADDR_ANALOG: begin
          analog_ref_gain <= pwdata[7:0];
          analog_ref_bias <= pwdata[15:8];
          ref_upper_limit <= pwdata[23:16];
          ref_lower_limit <= pwdata[31:24];
        end
        drc_pkg::ADDR_INFUNC: input_function_sel <= pwdata[27:0];
        drc_pkg::ADDR_JOG: jog_freq_ref <= pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // Ramp times saturate at the top of the coarse range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accel_time_a <= drc_pkg::RAMP_TIME_RST;
      decel_time_a <= drc_pkg::RAMP_TIME_RST;
      accel_time_b <= drc_pkg::RAMP_TIME_RST;
      decel_time_b <= drc_pkg::RAMP_TIME_RST;
    end else if (wr_en && paddr == drc_pkg::ADDR_RAMP_A) begin
      accel_time_a <= (pwdata[15:0] > drc_pkg::RAW_MAX) ? drc_pkg::RAW_MAX : pwdata[15:0];
      decel_time_a <= (pwdata[31:16] > drc_pkg::RAW_MAX) ? drc_pkg::RAW_MAX : pwdata[31:16];
    end else if (wr_en && paddr == drc_pkg::ADDR_RAMP_B) begin
      accel_time_b <= (pwdata[15:0] > drc_pkg::RAW_MAX) ? drc_pkg::RAW_MAX : pwdata[15:0];
      decel_time_b <= (pwdata[31:16] > drc_pkg::RAW_MAX) ? drc_pkg::RAW_MAX : pwdata[31:16];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        preset_q[i] <= drc_pkg::PRESET_RST;
      end
    end else if (wr_en && preset_hit) begin
      preset_q[preset_idx] <= pwdata[15:0];
    end
  end

  // Numeric panel entry and the value that actually drives the reference
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_entry_q <= 16'h0000;
      panel_ref_q <= 16'h0000;
    end else begin
      if (wr_en && paddr == drc_pkg::ADDR_PANEL_REF) begin
        panel_entry_q <= pwdata[15:0];
        if (enter_key_mode) begin
          panel_ref_q <= pwdata[15:0];
        end
      end else if (!enter_key_mode && panel_enter_key) begin
        panel_ref_q <= panel_entry_q;
      end
    end
  end

  // Stop key wins so a simultaneous press never leaves the panel run command set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_run_q <= 1'b0;
    end else if (panel_stop_key) begin
      panel_run_q <= 1'b0;
    end else if (panel_run_key) begin
      panel_run_q <= 1'b1;
    end
  end

  // Contact function decode: a function is on when any input assigned to it is on
  always_comb begin
    fn_on = '0;
    locrem_assigned = 1'b0;
    for (int i = 0; i < drc_pkg::NUM_CONTACTS; i++) begin
      if (contact_in[i]) begin
        fn_on[input_function_sel[4*i +: 4]] = 1'b1;
      end
      if (input_function_sel[4*i +: 4] == drc_pkg::FN_LOC_REM) begin
        locrem_assigned = 1'b1;
      end
    end
  end

  assign local_mode = locrem_assigned ? fn_on[drc_pkg::FN_LOC_REM] :
                      ctrl_q[drc_pkg::CTRL_LOCAL_BIT];
  assign step_idx = {fn_on[drc_pkg::FN_STEP4], fn_on[drc_pkg::FN_STEP3],
                     fn_on[drc_pkg::FN_STEP2], fn_on[drc_pkg::FN_STEP1]};

  // Run command source
  always_comb begin
    run_fwd = 1'b0;
    run_rev = 1'b0;
    if (local_mode) begin
      run_fwd = panel_run_q && !panel_dir_rev;
      run_rev = panel_run_q && panel_dir_rev;
    end else begin
      unique case (drc_pkg::drc_run_src_t'(run_cmd_source_sel))
        drc_pkg::DRC_RUN_PANEL: begin
          run_fwd = panel_run_q && !panel_dir_rev;
          run_rev = panel_run_q && panel_dir_rev;
        end
        drc_pkg::DRC_RUN_CONTACT: begin
          run_fwd = fn_on[drc_pkg::FN_FWD];
          run_rev = fn_on[drc_pkg::FN_REV];
        end
        drc_pkg::DRC_RUN_SERIAL: begin
          run_fwd = serial_run_fwd;
          run_rev = serial_run_rev;
        end
        drc_pkg::DRC_RUN_OPTION: begin
          run_fwd = option_run_fwd;
          run_rev = option_run_rev;
        end
      endcase
    end
    // Both directions at once is treated as stop
    want_rev = run_rev && !run_fwd;
    run_cmd = (run_fwd && !run_rev) || (want_rev && !reverse_prohibit);
  end

  // Reference selection
  always_comb begin
    base_ref = 16'h0000;
    if (local_mode) begin
      base_ref = local_ref_source_sel ? panel_ref_q :
                 scale_ref(panel_pot, 1'b0, max_output_freq, drc_pkg::GAIN_RST, drc_pkg::BIAS_RST);
    end else begin
      unique case (remote_ref_source_sel)
        4'h0: base_ref = scale_ref(panel_pot, 1'b0, max_output_freq, drc_pkg::GAIN_RST,
                                   drc_pkg::BIAS_RST);
        4'h1: base_ref = preset_q[0];
        4'h2: base_ref = scale_ref(analog_ref_input_pin, 1'b0, max_output_freq,
                                   analog_ref_gain, analog_ref_bias);
        4'h3: base_ref = scale_ref(analog_cur_in, 1'b1, max_output_freq,
                                   analog_ref_gain, analog_ref_bias);
        4'h4: base_ref = scale_ref(analog_cur_in, 1'b0, max_output_freq,
                                   analog_ref_gain, analog_ref_bias);
        4'h5: base_ref = pulse_freq_ref;
        4'h6: base_ref = serial_freq_ref;
        4'h7: base_ref = scale_ref(panel_volt_in, 1'b0, max_output_freq,
                                   analog_ref_gain, analog_ref_bias);
        4'h8: base_ref = scale_ref(panel_cur_in, 1'b1, max_output_freq,
                                   analog_ref_gain, analog_ref_bias);
        4'h9: base_ref = option_freq_ref;
        default: base_ref = 16'h0000;
      endcase
    end
    sel_ref = base_ref;
    if (fn_on[drc_pkg::FN_JOG]) begin
      sel_ref = jog_freq_ref;
    end else if (!local_mode && step_idx == 4'h1 && analog_step_sel) begin
      sel_ref = scale_ref(aux_analog_connector, 1'b0, max_output_freq,
                          analog_ref_gain, analog_ref_bias);
    end else if (!local_mode && step_idx != 4'h0) begin
      sel_ref = preset_q[step_idx];
    end
  end

  // Limits
  assign upper_chz = pct_chz(max_output_freq, ref_upper_limit);
  assign lower_chz = pct_chz(max_output_freq, ref_lower_limit);
  assign min_chz = 16'(32'(min_output_freq) * 32'(drc_pkg::DHZ_TO_CHZ));
  assign max_chz = 16'(32'(max_output_freq) * 32'(drc_pkg::DHZ_TO_CHZ));
  always_comb begin
    lim_ref = sel_ref;
    if (lim_ref > upper_chz) begin
      lim_ref = upper_chz;
    end
    if (lim_ref < lower_chz) begin
      lim_ref = lower_chz;
    end
    no_run = (sel_ref == 16'h0000) && (lower_chz < min_chz);
    target = (run_cmd && !no_run) ? lim_ref : 16'h0000;
  end

  // Ramp timing: pair chosen by contact function, accel while rising
  assign acc_cs = fn_on[drc_pkg::FN_RAMP_SEL] ? to_cs(accel_time_b, ramp_time_unit_sel) :
                  to_cs(accel_time_a, ramp_time_unit_sel);
  assign dec_cs = fn_on[drc_pkg::FN_RAMP_SEL] ? to_cs(decel_time_b, ramp_time_unit_sel) :
                  to_cs(decel_time_a, ramp_time_unit_sel);
  logic rising;
  assign rising = (rev_q == want_rev) && (target > freq_q);
  assign time_cs = rising ? acc_cs : dec_cs;
  assign thresh = 40'(time_cs) * 40'(drc_pkg::CYC_PER_CS);
  assign acc_sum = acc_q + 40'(max_chz);

  // One 0.01 Hz step each time max_chz has been added thresh/max_chz times,
  // which spreads max frequency evenly over the selected time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_q <= 16'h0000;
      rev_q <= 1'b0;
      acc_q <= 40'h00_0000_0000;
    end else if (freq_q == 16'h0000 && rev_q != want_rev && target != 16'h0000) begin
      rev_q <= want_rev;
      acc_q <= 40'h00_0000_0000;
    end else if ((rev_q != want_rev && freq_q != 16'h0000) || freq_q != target) begin
      if (time_cs == 20'h00000) begin
        freq_q <= (rev_q != want_rev) ? 16'h0000 : target;
        acc_q <= 40'h00_0000_0000;
      end else if (acc_sum >= thresh) begin
        freq_q <= rising ? freq_q + 16'h0001 : freq_q - 16'h0001;
        acc_q <= acc_sum - thresh;
      end else begin
        acc_q <= acc_sum;
      end
    end else begin
      acc_q <= 40'h00_0000_0000;
    end
  end

  assign out_freq = freq_q;
  assign out_reverse = rev_q;
  assign out_running = (freq_q != 16'h0000) || (target != 16'h0000);
endmodule
`default_nettype wire

/* File: verif/drc_panel_model.sv */
// Purpose: Operator panel and contact terminals facing the block
// Assumes: Keys are one-cycle pulses, contacts are levels
// Notes: Driven only after a rising edge so the block never sees a half-cycle key
`timescale 1ns/1ps
`default_nettype none
module drc_panel_model (
  input wire logic pclk,
  output logic run_key,
  output logic stop_key,
  output logic enter_key,
  output logic dir_rev,
  output logic [6:0] contacts
);
  initial {run_key, stop_key, enter_key, dir_rev, contacts} = 11'h000;
  task automatic press(input int k);
    run_key <= (k == 0);
    stop_key <= (k == 1);
    enter_key <= (k == 2);
    @(posedge pclk);
    {run_key, stop_key, enter_key} <= 3'h0;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

/* File: verif/drc_top_monitor.sv */
// Purpose: Port checks for the command, reference and ramp block
// Assumes: Maximum frequency stays at its reset value
// Notes: Bound to drc_top
`timescale 1ns/1ps
`default_nettype none
module drc_top_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] out_freq,
  input wire logic out_reverse,
  input wire logic out_running
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (psel && penable && paddr == 12'h024 |-> pslverr)
    else $error("unmapped access not refused");
  a_ctrl_mapped: assert property (psel && penable && paddr == 12'h000 |-> !pslverr)
    else $error("mapped access refused");
  a_read_idle: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside a read");
  a_freq_cap: assert property (out_freq <= 16'h1770) else $error("above limit");
  a_run_flag: assert property (out_freq != 16'h0 |-> out_running)
    else $error("turning while not running");
  a_dir_zero: assert property ($changed(out_reverse) |-> $past(out_freq) == 16'h0)
    else $error("direction flipped above zero");
  a_rise_run: assert property (out_freq > $past(out_freq) |-> $past(out_running))
    else $error("rise without run");
endmodule
bind drc_top drc_top_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .out_freq(out_freq), .out_reverse(out_reverse), .out_running(out_running));
`default_nettype wire

/* File: verif/drc_top_tb.sv */
// Purpose: Self-checking bench for the command, reference and ramp block
// Assumes: Ramp times set to zero in the source test to keep the run short; the ramp test leaves contact 2 on, so ramp B is selected in the local test
// Notes: Analog sources are full scale only when selected, so a wrong pick shows as zero
`timescale 1ns/1ps
`default_nettype none
module drc_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, run_fwd = 0, rrev = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, out_reverse, out_running, local_mode, rk, sk, ek, dr;
  logic [9:0] hot = 10'h000;
  logic [15:0] rv = 16'h0100, out_freq, ex;
  logic [6:0] ct;
  int bad_count = 0, n_compared = 0, n;
  always #20 pclk = ~pclk;
  drc_panel_model i_panel (.pclk(pclk), .run_key(rk), .stop_key(sk), .enter_key(ek),
    .dir_rev(dr), .contacts(ct));
  drc_top i_drc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .panel_run_key(rk), .panel_stop_key(sk), .panel_dir_rev(dr),
    .panel_enter_key(ek), .panel_pot({12{hot[0]}}), .contact_in(ct),
    .serial_run_fwd(run_fwd), .serial_run_rev(rrev), .serial_freq_ref(rv + 16'h0010),
    .option_run_fwd(run_fwd), .option_run_rev(rrev), .option_freq_ref(rv + 16'h0020),
    .analog_ref_input_pin({12{hot[2]}}), .analog_cur_in({12{hot[3] | hot[4]}}),
    .pulse_freq_ref(rv), .panel_volt_in({12{hot[7]}}), .panel_cur_in({12{hot[8]}}),
    .aux_analog_connector(rv[11:0]), .out_freq(out_freq), .out_reverse(out_reverse),
    .out_running(out_running), .local_mode(local_mode));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic settle(input logic [15:0] exp, input int lim);
    for (n = 0; out_freq !== exp && n < lim; n++) @(posedge pclk);
  endtask
  task automatic t_sources;
    apb(1, 12'h00C, 32'h0); apb(1, 12'h010, 32'h0); apb(1, 12'h040, 32'h130);
    i_panel.contacts <= 7'h01;
    for (int c = 0; c < 10; c++) begin
      hot <= 10'h001 << c;
      apb(1, 12'h000, {24'h0, 4'(c), 4'h1}); // Panel detection left 0
      ex = (c == 1) ? 16'h0130 : (c == 5) ? 16'h0100 : (c == 6) ? 16'h0110 :
           (c == 9) ? 16'h0120 : 16'h1770;
      settle(ex, 20);
      check(out_freq, ex);
    end
    i_panel.contacts <= 7'h00;
    for (int s = 0; s < 4; s++) begin
      apb(1, 12'h000, {28'h1, 2'h0, 2'(s)});
      if (s == 0) i_panel.press(0); else if (s == 1) i_panel.contacts <= 7'h01; else run_fwd <= 1'b1;
      settle(16'h0130, 20); check(out_freq, 16'h0130);
      if (s == 0) i_panel.press(1); else begin i_panel.contacts <= 7'h00; run_fwd <= 1'b0; end
      settle(16'h0, 20); check(out_freq, 16'h0);
      if (s > 1) begin
        rrev <= 1'b1;
        settle(16'h0130, 20);
        check(out_reverse, 1'b1);
        rrev <= 1'b0;
        settle(16'h0, 20);
      end
    end
    $display("sources done");
  endtask
  task automatic t_steps;
    apb(1, 12'h044, 32'h200); apb(1, 12'h048, 32'h300); apb(1, 12'h020, 32'h50);
    apb(1, 12'h000, 32'h11);
    i_panel.contacts <= 7'h11; settle(16'h0200, 20); check(out_freq, 16'h0200);
    apb(1, 12'h000, 32'h811); settle(16'h0177, 20); check(out_freq, 16'h0177);
    apb(1, 12'h000, 32'h11);
    i_panel.contacts <= 7'h21; settle(16'h0300, 20); check(out_freq, 16'h0300);
    i_panel.contacts <= 7'h71; settle(16'h0050, 20); check(out_freq, 16'h0050);
    i_panel.contacts <= 7'h01; settle(16'h0130, 20); check(out_freq, 16'h0130);
    apb(1, 12'h000, 32'h411); i_panel.contacts <= 7'h02; settle(16'h0, 20);
    repeat (5) @(posedge pclk);
    check({out_freq, out_reverse}, 17'h0);
    apb(1, 12'h000, 32'h11); settle(16'h0130, 20); check(out_reverse, 1'b1);
    i_panel.contacts <= 7'h00; settle(16'h0, 20);
    $display("steps done");
  endtask
  task automatic t_ramp;
    apb(1, 12'h000, 32'h10011); apb(1, 12'h00C, 32'h10001); apb(1, 12'h014, 32'hA765B21);
    i_panel.contacts <= 7'h01; @(posedge pclk); settle(16'h0130, 14000);
    check(n >= 12600 && n <= 12760, 1'b1);
    apb(1, 12'h000, 32'h11); apb(0, 12'h000, 32'h0); check(rd[16], 1'b1);
    i_panel.contacts <= 7'h04; @(posedge pclk); settle(16'h0, 3); check(out_freq, 16'h0);
    $display("ramp done");
  endtask
  task automatic t_local;
    apb(1, 12'h000, 32'h12100); check(local_mode, 1'b1);
    i_panel.press(0); repeat (5) @(posedge pclk); check(out_running, 1'b0);
    apb(1, 12'h018, 32'h100); repeat (5) @(posedge pclk); check(out_running, 1'b0);
    i_panel.press(2); settle(16'h0100, 20); check(out_freq, 16'h0100);
    i_panel.dir_rev <= 1'b1;
    repeat (5) @(posedge pclk);
    check({out_freq, out_reverse}, 17'h00201);
    apb(1, 12'h008, 32'h0A32_0064);
    settle(16'h0258, 20); check(out_freq, 16'h0258);
    i_panel.press(1); settle(16'h0, 20); check(out_freq, 16'h0);
    apb(1, 12'h014, 32'hC765B21); check(local_mode, 1'b0);
    i_panel.contacts <= 7'h40; @(posedge pclk); check(local_mode, 1'b1);
    $display("local done");
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 12'h000, 32'h0); check(rd, drc_pkg::CTRL_RST);
    apb(0, 12'h024, 32'h0); check(err, 1'b1);
    t_sources; t_steps; t_ramp; t_local;
    stop_test;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    bad_count++;
    stop_test;
  end
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
endmodule
`default_nettype wire
